// *** shared/ucs_pkg.sv ***
// Purpose: Constants for the USB control/status word 0 block
// Assumes: Classic Wishbone slave, 32-bit data, byte address on wb_adr
// Notes: All offsets, field positions and counts live here, plus the speed-allow and function address reset values
// What this block does
// - Bits 23:17 flag pending transmit interrupts of endpoints 1 to 7
// - Bit 16 flags a pending control endpoint zero interrupt
// - Reading the flag byte clears all endpoint flags in it
// - With bit 15 set, a loaded packet waits for the next frame start
// - Frame-start holding only for isochronous endpoints in device role
// - Bit 14 enables the data lines in device role, else high impedance
// - Bit 13 allows high-speed negotiation during bus reset; resets to one
// - Bit 12 reports high speed negotiated during the bus reset
// - Speed status valid only after bus reset ends or reset bit clears
// - Bit 11 reads one while reset signalling is on the bus
// - Reset bit writable in host role, read-only in device role
package ucs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CSR0_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam int unsigned NUM_TX_EP = 7;
  localparam int unsigned TXIF_LSB = 17;
  localparam int unsigned CTRL_ENDPOINT_IRQ_FLAG_BIT = 16;
  localparam int unsigned ISO_BIT = 15;
  localparam int unsigned SOFT_BIT = 14;
  localparam int unsigned HIGH_SPEED_ALLOW_BIT = 13;
  localparam int unsigned HIGH_SPEED_ACTIVE_BIT = 12;
  localparam int unsigned RESET_BIT = 11;
  localparam int unsigned RESUME_BIT = 10;
  localparam int unsigned SUSPM_BIT = 9;
  localparam int unsigned SUSPEND_ALLOW_BIT = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FLAG_LANE = 2;
  localparam int unsigned CTRL_LANE = 1;
  localparam int unsigned ADDR_LANE = 0;
  localparam int unsigned HOST_ROLE_BIT = 0;
  localparam logic HIGH_SPEED_ALLOW_RST = 1'b1;
  localparam logic [6:0] FADDR_RST = 7'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [0:0] {SPD_RUN, SPD_BUS_RESET} ucs_spd_type;
endpackage

// *** logic/ucs_pin_sync.sv ***
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to core_clk
// Notes: A change counts only once stages two and three agree
module ucs_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, level_ff;
  logic [WIDTH-1:0] nxt_level;

  if (WIDTH < 1) begin : g_chk
    $error("ucs_pin_sync: WIDTH must be at least 1");
  end

  // Only s2 reads s1, keeping the metastable stage isolated
  always_comb begin
    for (int i = 0; i < int'(WIDTH); i++) begin
      nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;
endmodule // ucs_pin_sync

// *** logic/ucs_iso_hold.sv ***
// Purpose: Per-endpoint release of loaded transmit packets
// Assumes: Load and frame-start strobes are one-cycle pulses on core_clk
// Notes: A held packet goes out on the first frame start after its load
module ucs_iso_hold #(
  parameter int unsigned NUM_EP = 7
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hold_en,
  input wire logic [NUM_EP-1:0] ep_is_iso,
  input wire logic [NUM_EP-1:0] tx_packet_loaded,
  input wire logic sof_token,
  output logic [NUM_EP-1:0] tx_send
);
  logic [NUM_EP-1:0] wait_ff, send_ff;
  logic [NUM_EP-1:0] nxt_wait, nxt_send;

  if (NUM_EP < 1 || NUM_EP > 7) begin : g_chk
    $error("ucs_iso_hold: NUM_EP must be 1 to 7");
  end

  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    logic hold;
    assign hold = hold_en & ep_is_iso[e];
    always_comb begin
      nxt_wait[e] = wait_ff[e];
      nxt_send[e] = 1'b0;
      if (wait_ff[e] && sof_token) begin
        nxt_wait[e] = 1'b0;
        nxt_send[e] = 1'b1;
      end
      // A load in a frame-start cycle waits for the next frame start
      if (tx_packet_loaded[e]) begin
        if (hold) begin
          nxt_wait[e] = 1'b1;
        end else begin
          nxt_send[e] = 1'b1;
        end
      end
      // Dropping the mode releases anything still parked
      if (!hold && wait_ff[e]) begin
        nxt_wait[e] = 1'b0;
        nxt_send[e] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_ff <= '0;
      send_ff <= '0;
    end else begin
      wait_ff <= nxt_wait;
      send_ff <= nxt_send;
    end
  end

  assign tx_send = send_ff;
endmodule // ucs_iso_hold

// *** logic/ucs_top.sv ***
// Purpose: USB control/status word 0 with Wishbone register access
// Assumes: Link events are core_clk pulses; bus reset arrives on a pin
// Notes: One access per request, ack one cycle after the strobe
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
module ucs_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ucs_pkg::ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_wdata,
  output logic [31:0] wb_rdata,
  output logic wb_ack,
  input wire logic [ucs_pkg::NUM_TX_EP-1:0] tx_ep_irq_evt,
  input wire logic ctrl_ep_irq_evt,
  input wire logic [ucs_pkg::NUM_TX_EP-1:0] tx_packet_loaded,
  input wire logic [ucs_pkg::NUM_TX_EP-1:0] ep_is_iso,
  input wire logic sof_token,
  input wire logic bus_reset_pin,
  input wire logic hs_chirp_ok,
  input wire logic suspend_evt,
  input wire logic resume_evt,
  output logic [ucs_pkg::NUM_TX_EP-1:0] tx_send,
  output logic line_oe,
  output logic hs_negotiate_en,
  output logic high_speed_active,
  output logic reset_drive,
  output logic resume_drive,
  output logic suspend_state,
  output logic [ucs_pkg::FADDR_W-1:0] function_address
);
  import ucs_pkg::*;

  if (CTRL_ENDPOINT_IRQ_FLAG_BIT != 8 * FLAG_LANE || TXIF_LSB != CTRL_ENDPOINT_IRQ_FLAG_BIT + 1) begin : g_chk_flags
    $error("ucs_top: control flag must open the flag byte, transmit flags above it");
  end
  if (NUM_TX_EP < 1 || TXIF_LSB + NUM_TX_EP > 8 * FLAG_LANE + 8) begin : g_chk_eps
    $error("ucs_top: transmit flags must fit the flag byte");
  end
  // Control fields share one lane, the function address another
  if (ISO_BIT / 8 != CTRL_LANE || SUSPEND_ALLOW_BIT / 8 != CTRL_LANE) begin : g_chk_ctrl
    $error("ucs_top: control fields must sit in the control lane");
  end
  if (FADDR_W < 1 || FADDR_W > 8 * ADDR_LANE + 8) begin : g_chk_addr
    $error("ucs_top: function address must fit the address lane");
  end
  // Offsets are compared from bit 2 up, so the bus needs at least three bits
  if (ADDR_W < 3 || ADDR_W > 8) begin : g_chk_bus
    $error("ucs_top: bus address must be 3 to 8 bits wide");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // Bus group
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic req;
  logic rd_take, wr_take;
  logic flag_rd;
  logic csr0_hit;
  logic cfg_hit;

  // Register group
  logic host_role_ff, nxt_host_role;
  logic iso_wait_frame_start_ff, nxt_iso;
  logic soft_attach_ff, nxt_soft;
  logic high_speed_allow_ff, nxt_high_speed_allow;
  logic reset_drive_ff, nxt_reset_drive;
  logic resume_ff, nxt_resume;
  logic suspend_allow_ff, nxt_suspend_allow;
  logic suspend_state_ff, nxt_suspm;
  logic [FADDR_W-1:0] function_address_ff, nxt_faddr;
  logic line_oe_ff, nxt_line_oe;

  // Flag group
  logic [NUM_TX_EP-1:0] tx_endpoint_irq_flags_ff, nxt_txif;
  logic ctrl_endpoint_irq_flag_ff, nxt_ctrl_endpoint_irq_flag;

  // Speed group
  ucs_spd_type spd_ff, nxt_spd;
  logic hs_seen_ff, nxt_hs_seen;
  logic high_speed_active_ff, nxt_high_speed_active;

  logic bus_reset_level;
  logic reset_present;
  logic [31:0] csr0_view;
  logic [31:0] cfg_view;

  ucs_pin_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .core_clk(core_clk),
    .srst(srst),
    .pin(bus_reset_pin),
    .level(bus_reset_level)
  );

  // Device role sees the line; host role sees its own drive
  assign reset_present = host_role_ff ? reset_drive_ff : bus_reset_level;

  assign csr0_hit = hit(wb_adr, CSR0_OFS);
  assign cfg_hit = hit(wb_adr, CFG_OFS);
  assign req = wb_cyc & wb_stb & ~ack_ff;
  assign rd_take = req & ~wb_we;
  assign wr_take = req & wb_we;
  // Only a read with the flag lane enabled clears; other lanes leave flags
  assign flag_rd = rd_take & hit(wb_adr, CSR0_OFS) & wb_sel[FLAG_LANE];

  always_comb begin
    csr0_view = 32'h0000_0000;
    csr0_view[TXIF_LSB +: NUM_TX_EP] = tx_endpoint_irq_flags_ff;
    csr0_view[CTRL_ENDPOINT_IRQ_FLAG_BIT] = ctrl_endpoint_irq_flag_ff;
    csr0_view[ISO_BIT] = iso_wait_frame_start_ff & ~host_role_ff;
    csr0_view[SOFT_BIT] = soft_attach_ff;
    csr0_view[HIGH_SPEED_ALLOW_BIT] = high_speed_allow_ff;
    csr0_view[HIGH_SPEED_ACTIVE_BIT] = high_speed_active_ff;
    csr0_view[RESET_BIT] = reset_present;
    csr0_view[RESUME_BIT] = resume_ff;
    csr0_view[SUSPM_BIT] = suspend_state_ff;
    csr0_view[SUSPEND_ALLOW_BIT] = suspend_allow_ff;
    csr0_view[FADDR_W-1:0] = function_address_ff;
  end

  // Only the role select is implemented in the config word
  always_comb begin
    cfg_view = 32'h0000_0000;
    cfg_view[HOST_ROLE_BIT] = host_role_ff;
  end

  always_comb begin
    nxt_ack = req;
    nxt_rdata = rdata_ff;
    if (rd_take) begin
      if (hit(wb_adr, CSR0_OFS)) begin
        nxt_rdata = csr0_view;
      end else if (hit(wb_adr, CFG_OFS)) begin
        nxt_rdata = cfg_view;
      end else begin
        nxt_rdata = UNMAPPED_DATA;
      end
      // Disabled byte lanes read as zero
      for (int b = 0; b < 4; b++) begin
        if (!wb_sel[b]) begin
          nxt_rdata[8*b +: 8] = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // Config group: the role select lives in its own register
  always_comb begin
    nxt_host_role = host_role_ff;
    if (wr_take && cfg_hit && wb_sel[0]) begin
      nxt_host_role = wb_wdata[HOST_ROLE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      host_role_ff <= 1'b0;
    end else begin
      host_role_ff <= nxt_host_role;
    end
  end

  // Control group
  always_comb begin
    nxt_iso = iso_wait_frame_start_ff;
    nxt_soft = soft_attach_ff;
    nxt_high_speed_allow = high_speed_allow_ff;
    nxt_reset_drive = reset_drive_ff;
    nxt_resume = resume_ff;
    nxt_suspend_allow = suspend_allow_ff;
    nxt_faddr = function_address_ff;
    if (wr_take && csr0_hit) begin
      if (wb_sel[CTRL_LANE]) begin
        if (!host_role_ff) begin
          nxt_iso = wb_wdata[ISO_BIT];
        end
        nxt_soft = wb_wdata[SOFT_BIT];
        nxt_high_speed_allow = wb_wdata[HIGH_SPEED_ALLOW_BIT];
        if (host_role_ff) begin
          nxt_reset_drive = wb_wdata[RESET_BIT];
        end
        nxt_resume = wb_wdata[RESUME_BIT];
        nxt_suspend_allow = wb_wdata[SUSPEND_ALLOW_BIT];
      end
      if (wb_sel[ADDR_LANE]) begin
        nxt_faddr = wb_wdata[FADDR_W-1:0];
      end
    end
    // Switching to device role drops a host-driven reset
    if (!nxt_host_role) begin
      nxt_reset_drive = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      iso_wait_frame_start_ff <= 1'b0;
      soft_attach_ff <= 1'b0;
      high_speed_allow_ff <= HIGH_SPEED_ALLOW_RST;
      reset_drive_ff <= 1'b0;
      resume_ff <= 1'b0;
      suspend_allow_ff <= 1'b0;
      function_address_ff <= FADDR_RST;
    end else begin
      iso_wait_frame_start_ff <= nxt_iso;
      soft_attach_ff <= nxt_soft;
      high_speed_allow_ff <= nxt_high_speed_allow;
      reset_drive_ff <= nxt_reset_drive;
      resume_ff <= nxt_resume;
      suspend_allow_ff <= nxt_suspend_allow;
      function_address_ff <= nxt_faddr;
    end
  end

  // Suspend group: hardware sets and clears, software only arms and resumes
  always_comb begin
    nxt_suspm = suspend_state_ff;
    // Entering suspend wins over a same-cycle resume, so a fresh suspend is kept
    if (resume_evt || (resume_ff && !nxt_resume)) begin
      nxt_suspm = 1'b0;
    end
    if (suspend_evt && suspend_allow_ff) begin
      nxt_suspm = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      suspend_state_ff <= 1'b0;
    end else begin
      suspend_state_ff <= nxt_suspm;
    end
  end

  // Lines float whenever soft attach is off; host role owns them elsewhere
  always_comb begin
    nxt_line_oe = soft_attach_ff & ~host_role_ff;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      line_oe_ff <= 1'b0;
    end else begin
      line_oe_ff <= nxt_line_oe;
    end
  end

  // New events win over the read that clears, so none is lost
  always_comb begin
    nxt_txif = tx_endpoint_irq_flags_ff;
    nxt_ctrl_endpoint_irq_flag = ctrl_endpoint_irq_flag_ff;
    if (flag_rd) begin
      nxt_txif = '0;
      nxt_ctrl_endpoint_irq_flag = 1'b0;
    end
    nxt_txif = nxt_txif | tx_ep_irq_evt;
    nxt_ctrl_endpoint_irq_flag = nxt_ctrl_endpoint_irq_flag | ctrl_ep_irq_evt;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_endpoint_irq_flags_ff <= '0;
      ctrl_endpoint_irq_flag_ff <= 1'b0;
    end else begin
      tx_endpoint_irq_flags_ff <= nxt_txif;
      ctrl_endpoint_irq_flag_ff <= nxt_ctrl_endpoint_irq_flag;
    end
  end

  // Speed result is only published when the reset phase ends
  always_comb begin
    nxt_spd = spd_ff;
    nxt_hs_seen = hs_seen_ff;
    nxt_high_speed_active = high_speed_active_ff;
    unique case (spd_ff)
      SPD_RUN: begin
        if (reset_present) begin
          nxt_spd = SPD_BUS_RESET;
          nxt_hs_seen = 1'b0;
          nxt_high_speed_active = 1'b0;
        end
      end
      SPD_BUS_RESET: begin
        if (hs_chirp_ok && high_speed_allow_ff) begin
          nxt_hs_seen = 1'b1;
        end
        if (!reset_present) begin
          nxt_spd = SPD_RUN;
          // A chirp in the last reset cycle still counts
          nxt_high_speed_active = (hs_seen_ff || hs_chirp_ok) && high_speed_allow_ff;
        end
      end
    endcase
    // Full speed at once whenever negotiation is forbidden
    if (!high_speed_allow_ff) begin
      nxt_high_speed_active = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      spd_ff <= SPD_RUN;
      hs_seen_ff <= 1'b0;
      high_speed_active_ff <= 1'b0;
    end else begin
      spd_ff <= nxt_spd;
      hs_seen_ff <= nxt_hs_seen;
      high_speed_active_ff <= nxt_high_speed_active;
    end
  end

  // Holding applies only in device role
  ucs_iso_hold #(
    .NUM_EP(NUM_TX_EP)
  ) u_iso_hold (
    .core_clk(core_clk),
    .srst(srst),
    .hold_en(iso_wait_frame_start_ff & ~host_role_ff),
    .ep_is_iso(ep_is_iso),
    .tx_packet_loaded(tx_packet_loaded),
    .sof_token(sof_token),
    .tx_send(tx_send)
  );

  assign wb_ack = ack_ff;
  assign wb_rdata = rdata_ff;
  assign line_oe = line_oe_ff;
  assign hs_negotiate_en = high_speed_allow_ff;
  assign high_speed_active = high_speed_active_ff;
  assign reset_drive = reset_drive_ff;
  assign resume_drive = resume_ff;
  assign suspend_state = suspend_state_ff;
  assign function_address = function_address_ff;
endmodule // ucs_top

// *** testbench/ucs_top_properties.sv ***
// Purpose: Port-level checks for the control/status word block
// Assumes: One clock domain, srst synchronous active high
// Notes: Output copies may lag their register by one cycle, hence short ranges
module ucs_top_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic wb_ack,
  input wire logic [ucs_pkg::NUM_TX_EP-1:0] tx_packet_loaded,
  input wire logic [ucs_pkg::NUM_TX_EP-1:0] ep_is_iso,
  input wire logic bus_reset_pin,
  input wire logic suspend_evt,
  input wire logic resume_evt,
  input wire logic [ucs_pkg::NUM_TX_EP-1:0] tx_send,
  input wire logic hs_negotiate_en,
  input wire logic high_speed_active,
  input wire logic suspend_state,
  input wire logic [ucs_pkg::FADDR_W-1:0] function_address
);
  timeunit 1ns;
  timeprecision 1ps;
  import ucs_pkg::*;
  logic wr_req;
  logic [NUM_TX_EP-1:0] direct;
  assign wr_req = wb_cyc & wb_stb & wb_we;
  assign direct = tx_packet_loaded & ~ep_is_iso;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_ACK_NEXT: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  AST_NON_ISO_DIRECT: assert property (|direct |=> (tx_send & $past(direct)) == $past(direct))
    else $error("non-isochronous packet not sent next cycle");
  AST_RESET_VALUES: assert property ($fell(srst) |-> hs_negotiate_en && function_address == 0)
    else $error("wrong reset value");
  AST_HS_FORCED_LOW: assert property (!hs_negotiate_en [*2] |-> !high_speed_active)
    else $error("high speed active while not allowed");
  AST_HS_RISE: assert property ($rose(high_speed_active) |-> hs_negotiate_en)
    else $error("high speed rose without permission");
  AST_BUS_RESET_CLEARS_HS: assert property (bus_reset_pin [*8] |-> !high_speed_active)
    else $error("speed status kept through bus reset");
  AST_RESUME_CLEARS: assert property (resume_evt && !suspend_evt |-> ##[1:2] !suspend_state)
    else $error("suspend state not cleared by resume");
  AST_SUSPEND_CAUSE: assert property ($rose(suspend_state) |-> $past(suspend_evt) || $past(suspend_evt, 2))
    else $error("suspend state rose without event");
  AST_ADDR_BY_WRITE: assert property ($changed(function_address) |-> $past(wr_req) || $past(wr_req, 2))
    else $error("function address changed without write");
endmodule // ucs_top_props

// *** testbench/ucs_host_model.sv ***
// Purpose: Host or hub on the far side of the link
// Assumes: Events are one-cycle pulses on core_clk
// Notes: Chirp result is held as a level while reset signalling stands
module ucs_host_model (
  input wire logic core_clk,
  output logic sof_token,
  output logic bus_reset_pin,
  output logic hs_chirp_ok,
  output logic suspend_evt,
  output logic resume_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {sof_token, bus_reset_pin, hs_chirp_ok, suspend_evt, resume_evt} = 5'h00;
  end
  // Speed result is only offered while the reset stands, never after it
  task automatic line_reset(input logic on, input logic hs);
    @(posedge core_clk);
    bus_reset_pin <= on;
    hs_chirp_ok <= hs;
  endtask
  task automatic pulse(input int unsigned which);
    @(posedge core_clk);
    sof_token <= (which == 0);
    suspend_evt <= (which == 1);
    resume_evt <= (which == 2);
    @(posedge core_clk);
    {sof_token, suspend_evt, resume_evt} <= 3'h0;
  endtask
endmodule // ucs_host_model

// *** testbench/ucs_top_test.sv ***
// Purpose: Register-level regression of the control/status word block
// Assumes: Wishbone classic master, ack awaited under a bound
// Notes: Config register bit 0 selects host role
module ucs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ucs_pkg::*;
  logic core_clk = 0, srst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, ctrl_ep_irq_evt = 0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdata = 32'h0000_0000, wb_rdata, rd;
  logic [6:0] tx_ep_irq_evt = 7'h00, tx_packet_loaded = 7'h00, ep_is_iso = 7'h00, tx_send;
  logic [6:0] sent_acc, function_address;
  logic sof_token, bus_reset_pin, hs_chirp_ok, suspend_evt, resume_evt;
  logic line_oe, hs_negotiate_en, high_speed_active, reset_drive, resume_drive, suspend_state;
  int n_fail = 0, checks = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) sent_acc <= srst ? 7'h00 : (sent_acc | tx_send);
  ucs_host_model host (.core_clk(core_clk), .sof_token(sof_token), .bus_reset_pin(bus_reset_pin),
    .hs_chirp_ok(hs_chirp_ok), .suspend_evt(suspend_evt), .resume_evt(resume_evt));
  ucs_top uut (.core_clk(core_clk), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata), .wb_rdata(wb_rdata),
    .wb_ack(wb_ack), .tx_ep_irq_evt(tx_ep_irq_evt), .ctrl_ep_irq_evt(ctrl_ep_irq_evt),
    .tx_packet_loaded(tx_packet_loaded), .ep_is_iso(ep_is_iso), .sof_token(sof_token),
    .bus_reset_pin(bus_reset_pin), .hs_chirp_ok(hs_chirp_ok), .suspend_evt(suspend_evt),
    .resume_evt(resume_evt), .tx_send(tx_send), .line_oe(line_oe),
    .hs_negotiate_en(hs_negotiate_en), .high_speed_active(high_speed_active),
    .reset_drive(reset_drive), .resume_drive(resume_drive), .suspend_state(suspend_state),
    .function_address(function_address));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdata} <= {2'b11, we, adr, sel, wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1);
    rd = wb_rdata;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    chk("ack cycles", 32'h0000_0002, 32'(n));
  endtask
  task automatic rdchk(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] exp);
    access(1'b0, adr, sel, 32'h0000_0000);
    chk("read data", exp, rd);
  endtask
  task automatic finish_test;
    $display("Comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    tick(20000);
    n_fail++;
    finish_test;
  end
  initial begin
    tick(8);
    srst <= 0;
    rdchk(CSR0_OFS, 4'hF, 32'h0000_2000);
    rdchk(8'h10, 4'hF, 32'h0000_0000);
    access(1'b1, CSR0_OFS, 4'h1, 32'h0000_005A);
    access(1'b1, CSR0_OFS, 4'h2, 32'h0000_DB00);
    rdchk(CSR0_OFS, 4'h3, 32'h0000_C15A);
    chk("line_oe", 32'h0000_0001, {31'h0, line_oe});
    chk("function_address", 32'h0000_005A, {25'h0, function_address});
    @(posedge core_clk);
    {tx_ep_irq_evt, ctrl_ep_irq_evt} <= {7'h41, 1'b1};
    @(posedge core_clk);
    {tx_ep_irq_evt, ctrl_ep_irq_evt} <= 8'h00;
    rdchk(CSR0_OFS, 4'h3, 32'h0000_C15A);
    rdchk(CSR0_OFS, 4'h4, 32'h0083_0000);
    rdchk(CSR0_OFS, 4'h4, 32'h0000_0000);
    ep_is_iso <= 7'h01;
    @(posedge core_clk);
    tx_packet_loaded <= 7'h03;
    @(posedge core_clk);
    tx_packet_loaded <= 7'h00;
    tick(4);
    chk("held send", 32'h0000_0002, {25'h0, sent_acc});
    host.pulse(0);
    tick(3);
    chk("frame send", 32'h0000_0003, {25'h0, sent_acc});
    access(1'b1, CFG_OFS, 4'h1, 32'h0000_0001);
    rdchk(CSR0_OFS, 4'h2, 32'h0000_4100);
    chk("line_oe host", 32'h0000_0000, {31'h0, line_oe});
    access(1'b1, CSR0_OFS, 4'h2, 32'h0000_4900);
    rdchk(CSR0_OFS, 4'h2, 32'h0000_4900);
    chk("reset_drive", 32'h0000_0001, {31'h0, reset_drive});
    access(1'b1, CFG_OFS, 4'h1, 32'h0000_0000);
    access(1'b1, CSR0_OFS, 4'h2, 32'h0000_6100);
    chk("reset_drive off", 32'h0000_0000, {31'h0, reset_drive});
    host.line_reset(1'b1, 1'b1);
    tick(8);
    rdchk(CSR0_OFS, 4'h2, 32'h0000_6900);
    host.line_reset(1'b0, 1'b0);
    tick(8);
    rdchk(CSR0_OFS, 4'h2, 32'h0000_7100);
    chk("high_speed_active", 32'h0000_0001, {31'h0, high_speed_active});
    access(1'b1, CSR0_OFS, 4'h2, 32'h0000_4100);
    rdchk(CSR0_OFS, 4'h2, 32'h0000_4100);
    chk("hs_negotiate_en", 32'h0000_0000, {31'h0, hs_negotiate_en});
    chk("high_speed_active off", 32'h0000_0000, {31'h0, high_speed_active});
    host.pulse(1);
    tick(3);
    rdchk(CSR0_OFS, 4'h2, 32'h0000_4300);
    host.pulse(2);
    tick(3);
    chk("suspend_state", 32'h0000_0000, {31'h0, suspend_state});
    host.pulse(1);
    access(1'b1, CSR0_OFS, 4'h2, 32'h0000_4500);
    chk("resume_drive", 32'h0000_0001, {31'h0, resume_drive});
    chk("suspend kept", 32'h0000_0001, {31'h0, suspend_state});
    access(1'b1, CSR0_OFS, 4'h2, 32'h0000_4100);
    chk("resume_drive off", 32'h0000_0000, {31'h0, resume_drive});
    chk("suspend_state sw", 32'h0000_0000, {31'h0, suspend_state});
    finish_test;
  end
endmodule // ucs_top_test

bind ucs_top ucs_top_props u_props (.core_clk(core_clk), .srst(srst), .wb_cyc(wb_cyc),
  .wb_stb(wb_stb), .wb_we(wb_we), .wb_ack(wb_ack), .tx_packet_loaded(tx_packet_loaded),
  .ep_is_iso(ep_is_iso), .bus_reset_pin(bus_reset_pin), .suspend_evt(suspend_evt),
  .resume_evt(resume_evt), .tx_send(tx_send), .hs_negotiate_en(hs_negotiate_en),
  .high_speed_active(high_speed_active), .suspend_state(suspend_state),
  .function_address(function_address));
